// [rtl/ss_read_pkg.sv]
// constants and carrier types for the select-strobe read sequencer
package ss_read_pkg;

	localparam int ADDR_W = 22;
	localparam int BANK_W = 2;
	localparam int CS_W = 2;
	localparam int DATA_W = 16;
	localparam int WORD_W = 32;
	localparam int TA_W = 2;
	localparam int SETUP_W = 4;
	localparam int STROBE_W = 6;
	localparam int HOLD_W = 3;
	localparam int BEATS_W = 2;

	localparam logic SS_ENABLE_ON = 1'h1;
	localparam logic [TA_W-1:0] TA_ZERO = 2'h0;
	localparam logic [TA_W-1:0] TA_MIN = 2'h1;
	localparam logic [BEATS_W-1:0] BEATS_WIDE = 2'h1;
	localparam logic [BEATS_W-1:0] BEATS_NARROW = 2'h2;

	typedef struct packed {
		logic select_strobe_enable;
		logic narrow_bus;
		logic [TA_W-1:0] turnaround_count;
		logic [SETUP_W-1:0] read_setup_count;
		logic [STROBE_W-1:0] read_strobe_count;
		logic [HOLD_W-1:0] read_hold_count;
	} async_bank_config_s;

	typedef struct packed {
		logic [CS_W-1:0] cs;
		logic [ADDR_W-1:0] addr;
		logic [BANK_W-1:0] bank;
	} read_req_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TURN,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} phase_e;

endpackage : ss_read_pkg

// [rtl/ss_read_seq.sv]
// select-strobe read sequencer for an asynchronous memory port
`timescale 1ns/1ps

module ss_read_seq (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input ss_read_pkg::async_bank_config_s cfg_in [4],
	input wire logic req_valid_in,
	input ss_read_pkg::read_req_s req_in,
	output logic req_ready_out,
	output logic [ss_read_pkg::WORD_W-1:0] rd_data_out,
	output logic rd_valid_out,
	output logic busy_out,
	output logic write_enable_pin_b_out,
	output logic read_write_dir_pin_out,
	output logic chip_select_strobe_pin_b_out,
	output logic output_enable_pin_b_out,
	output logic [ss_read_pkg::ADDR_W-1:0] word_addr_pins_out,
	output logic [ss_read_pkg::BANK_W-1:0] bank_addr_pins_out,
	input wire logic [ss_read_pkg::DATA_W-1:0] data_bus_pins_in
);

	////////////////////////////////////////////////////////////////////////////
	// state

	ss_read_pkg::phase_e state_ff, nxt_state;
	logic [5:0] cnt_ff, nxt_cnt;
	logic [ss_read_pkg::SETUP_W-1:0] setup_ff, nxt_setup;
	logic [ss_read_pkg::STROBE_W-1:0] strobe_ff, nxt_strobe;
	logic [ss_read_pkg::HOLD_W-1:0] hold_ff, nxt_hold;
	logic [ss_read_pkg::BEATS_W-1:0] beats_ff, nxt_beats;
	logic [ss_read_pkg::BEATS_W-1:0] beat_ff, nxt_beat;
	ss_read_pkg::read_req_s cur_ff, nxt_cur;
	logic last_valid_ff, nxt_last_valid;
	logic [ss_read_pkg::CS_W-1:0] last_cs_ff, nxt_last_cs;
	logic [ss_read_pkg::WORD_W-1:0] data_ff, nxt_data;
	logic rd_valid_ff, nxt_rd_valid;
	logic ready_ff, nxt_ready;
	logic cs_b_ff, nxt_cs_b;
	logic oe_b_ff, nxt_oe_b;
	logic [ss_read_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
	logic [ss_read_pkg::BANK_W-1:0] bank_ff, nxt_bank;
	ss_read_pkg::async_bank_config_s acfg;
	logic take;
	logic [ss_read_pkg::SETUP_W-1:0] setup_cnt_ff, nxt_setup_cnt;
	logic in_setup_ff, nxt_in_setup;
	logic [ss_read_pkg::SETUP_W-1:0] acfg_next_setup;
	logic busy_ff, nxt_busy;
	logic pins_hi_ff, nxt_pins_hi;

	// turnaround cycles: zero if same space follows directly, at least one otherwise
	function automatic logic [5:0] turn_len(input ss_read_pkg::async_bank_config_s c, input logic same);
		logic [ss_read_pkg::TA_W-1:0] t;
		t = (c.turnaround_count == ss_read_pkg::TA_ZERO) ? ss_read_pkg::TA_MIN : c.turnaround_count;
		turn_len = same ? 6'h00 : {4'h0, t};
	endfunction : turn_len

	// count held as length minus one; a zero field still gives one cycle
	function automatic logic [5:0] ph_len(input logic [5:0] n);
		ph_len = (n == 6'h00) ? 6'h00 : n - 6'h01;
	endfunction : ph_len

	assign acfg = cfg_in[cur_ff.cs];
	assign take = req_valid_in && ready_ff;

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		ss_read_pkg::async_bank_config_s ncfg;
		logic [5:0] tl;
		ncfg = cfg_in[req_in.cs];
		tl = turn_len(ncfg, last_valid_ff && (last_cs_ff == req_in.cs));
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_setup = setup_ff;
		nxt_strobe = strobe_ff;
		nxt_hold = hold_ff;
		nxt_beats = beats_ff;
		nxt_beat = beat_ff;
		nxt_cur = cur_ff;
		nxt_last_valid = last_valid_ff;
		nxt_last_cs = last_cs_ff;
		nxt_data = data_ff;
		nxt_rd_valid = 1'b0;
		nxt_ready = ready_ff;
		nxt_cs_b = 1'b1;
		nxt_oe_b = 1'b1;
		nxt_addr = addr_ff;
		nxt_bank = bank_ff;
		case (state_ff)
			ss_read_pkg::ST_IDLE: begin
				nxt_last_valid = 1'b0;
				if (take) begin
					nxt_cur = req_in;
					nxt_ready = 1'b0;
					nxt_beat = '0;
					nxt_beats = ncfg.narrow_bus ? ss_read_pkg::BEATS_NARROW : ss_read_pkg::BEATS_WIDE;
					if (tl == 6'h00) begin
						nxt_state = ss_read_pkg::ST_SETUP;
					end else begin
						nxt_state = ss_read_pkg::ST_TURN;
						nxt_cnt = tl - 6'h01;
					end
				end
			end
			ss_read_pkg::ST_TURN: begin
				if (cnt_ff == 6'h00) begin
					nxt_state = ss_read_pkg::ST_SETUP;
				end else begin
					nxt_cnt = cnt_ff - 6'h01;
				end
			end
			ss_read_pkg::ST_SETUP: begin
				if (beat_ff == '0) begin
					nxt_setup = acfg.read_setup_count;
					nxt_strobe = acfg.read_strobe_count;
					nxt_hold = acfg.read_hold_count;
				end
				nxt_state = ss_read_pkg::ST_STROBE;
				nxt_cs_b = ~(acfg.select_strobe_enable == ss_read_pkg::SS_ENABLE_ON);
				nxt_oe_b = 1'b0;
				nxt_cnt = ph_len((beat_ff == '0) ? acfg.read_strobe_count : strobe_ff);
			end
			ss_read_pkg::ST_STROBE: begin
				if (cnt_ff == 6'h00) begin
					nxt_state = ss_read_pkg::ST_HOLD;
					nxt_cnt = ph_len({3'h0, hold_ff});
					// the memory keeps data valid up to the strobe release
					if (beats_ff == ss_read_pkg::BEATS_WIDE)
						nxt_data = {{(ss_read_pkg::WORD_W-ss_read_pkg::DATA_W){1'b0}}, data_bus_pins_in};
					else if (beat_ff == '0)
						nxt_data = {data_ff[ss_read_pkg::WORD_W-1:ss_read_pkg::DATA_W], data_bus_pins_in};
					else
						nxt_data = {data_bus_pins_in, data_ff[ss_read_pkg::DATA_W-1:0]};
				end else begin
					nxt_cnt = cnt_ff - 6'h01;
					nxt_cs_b = cs_b_ff;
					nxt_oe_b = 1'b0;
				end
			end
			ss_read_pkg::ST_HOLD: begin
				if (cnt_ff != 6'h00) begin
					nxt_cnt = cnt_ff - 6'h01;
				end else if (beat_ff + 2'h1 < beats_ff) begin
					nxt_beat = beat_ff + 2'h1;
					nxt_state = ss_read_pkg::ST_SETUP;
					nxt_cnt = 6'h00;
				end else begin
					nxt_rd_valid = 1'b1;
					nxt_last_valid = 1'b1;
					nxt_last_cs = cur_ff.cs;
					nxt_addr = '0;
					nxt_bank = '0;
					nxt_state = ss_read_pkg::ST_IDLE;
					nxt_ready = 1'b1;
				end
			end
			default: begin
				nxt_state = ss_read_pkg::ST_IDLE;
				nxt_ready = 1'b1;
			end
		endcase
		// setup phase length: wait setup count before strobe
		if (state_ff == ss_read_pkg::ST_SETUP && setup_cnt_ff != 4'h0) begin
			nxt_state = ss_read_pkg::ST_SETUP;
			nxt_cs_b = 1'b1;
			nxt_oe_b = 1'b1;
			nxt_cnt = cnt_ff;
		end
		// the address must stand from the first setup cycle, so it loads on the edge into setup
		if (nxt_state == ss_read_pkg::ST_SETUP) begin
			nxt_addr = nxt_cur.addr | {{(ss_read_pkg::ADDR_W-ss_read_pkg::BEATS_W){1'b0}}, nxt_beat};
			nxt_bank = nxt_cur.bank;
		end
		nxt_busy = ~nxt_ready;
		nxt_pins_hi = 1'b1;
	end

	// setup phase counter kept apart so loaded counts stay untouched

	always_comb begin
		nxt_in_setup = (nxt_state == ss_read_pkg::ST_SETUP);
		nxt_setup_cnt = setup_cnt_ff;
		if (nxt_in_setup && !in_setup_ff) begin
			if (state_ff == ss_read_pkg::ST_HOLD)
				nxt_setup_cnt = (setup_ff == 4'h0) ? 4'h0 : setup_ff - 4'h1;
			else
				nxt_setup_cnt = (acfg_next_setup == 4'h0) ? 4'h0 : acfg_next_setup - 4'h1;
		end else if (in_setup_ff && setup_cnt_ff != 4'h0) begin
			nxt_setup_cnt = setup_cnt_ff - 4'h1;
		end
	end

	assign acfg_next_setup = (state_ff == ss_read_pkg::ST_IDLE) ? cfg_in[req_in.cs].read_setup_count
		: acfg.read_setup_count;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= ss_read_pkg::ST_IDLE;
			cnt_ff <= 6'h00;
			setup_ff <= '0;
			strobe_ff <= '0;
			hold_ff <= '0;
			beats_ff <= ss_read_pkg::BEATS_WIDE;
			beat_ff <= '0;
			cur_ff <= '0;
			last_valid_ff <= 1'b0;
			last_cs_ff <= '0;
			data_ff <= '0;
			rd_valid_ff <= 1'b0;
			ready_ff <= 1'b1;
			cs_b_ff <= 1'b1;
			oe_b_ff <= 1'b1;
			addr_ff <= '0;
			bank_ff <= '0;
			setup_cnt_ff <= '0;
			in_setup_ff <= 1'b0;
			busy_ff <= 1'b0;
			pins_hi_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			setup_ff <= nxt_setup;
			strobe_ff <= nxt_strobe;
			hold_ff <= nxt_hold;
			beats_ff <= nxt_beats;
			beat_ff <= nxt_beat;
			cur_ff <= nxt_cur;
			last_valid_ff <= nxt_last_valid;
			last_cs_ff <= nxt_last_cs;
			data_ff <= nxt_data;
			rd_valid_ff <= nxt_rd_valid;
			ready_ff <= nxt_ready;
			cs_b_ff <= nxt_cs_b;
			oe_b_ff <= nxt_oe_b;
			addr_ff <= nxt_addr;
			bank_ff <= nxt_bank;
			setup_cnt_ff <= nxt_setup_cnt;
			in_setup_ff <= nxt_in_setup;
			busy_ff <= nxt_busy;
			pins_hi_ff <= nxt_pins_hi;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign req_ready_out = ready_ff;
	assign rd_data_out = data_ff;
	assign rd_valid_out = rd_valid_ff;
	assign busy_out = busy_ff;
	assign write_enable_pin_b_out = pins_hi_ff;
	assign read_write_dir_pin_out = pins_hi_ff;
	assign chip_select_strobe_pin_b_out = cs_b_ff;
	assign output_enable_pin_b_out = oe_b_ff;
	assign word_addr_pins_out = addr_ff;
	assign bank_addr_pins_out = bank_ff;

	////////////////////////////////////////////////////////////////////////////
	// checks

	property p_strobe_pair;
		@(posedge clk_in) disable iff (!rst_b_in)
		!oe_b_ff |-> state_ff == ss_read_pkg::ST_STROBE || $past(state_ff) == ss_read_pkg::ST_SETUP;
	endproperty
	a_strobe_pair: assert property (p_strobe_pair) else $error("oe low outside strobe");

	property p_cs_follows_oe;
		@(posedge clk_in) disable iff (!rst_b_in)
		!cs_b_ff |-> !oe_b_ff;
	endproperty
	a_cs_follows_oe: assert property (p_cs_follows_oe) else $error("cs low without oe");

	property p_release_captures;
		@(posedge clk_in) disable iff (!rst_b_in)
		$rose(oe_b_ff) |-> data_ff[ss_read_pkg::DATA_W-1:0] == $past(data_bus_pins_in)
			|| data_ff[ss_read_pkg::WORD_W-1:ss_read_pkg::DATA_W] == $past(data_bus_pins_in);
	endproperty
	a_release_captures: assert property (p_release_captures) else $error("data not captured");

	property p_turn_one;
		@(posedge clk_in) disable iff (!rst_b_in)
		take && !(last_valid_ff && last_cs_ff == req_in.cs) |=> state_ff == ss_read_pkg::ST_TURN;
	endproperty
	a_turn_one: assert property (p_turn_one) else $error("turnaround skipped");

	property p_same_skip;
		@(posedge clk_in) disable iff (!rst_b_in)
		take && last_valid_ff && last_cs_ff == req_in.cs |=> state_ff == ss_read_pkg::ST_SETUP;
	endproperty
	a_same_skip: assert property (p_same_skip) else $error("turnaround not skipped");

	property p_cont_setup;
		@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == ss_read_pkg::ST_HOLD && nxt_beat != beat_ff |=> state_ff == ss_read_pkg::ST_SETUP;
	endproperty
	a_cont_setup: assert property (p_cont_setup) else $error("continuation not into setup");

	property p_done_idle;
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_valid_ff |-> state_ff == ss_read_pkg::ST_IDLE && ready_ff;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("not idle after word");

	property p_keep_counts;
		@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == ss_read_pkg::ST_SETUP && beat_ff != '0 |=> $stable(strobe_ff) && $stable(hold_ff);
	endproperty
	a_keep_counts: assert property (p_keep_counts) else $error("counts reloaded");

endmodule : ss_read_seq

// [bench/ss_mem_model.sv]
// behavioural asynchronous memory on the far side of the read sequencer
`timescale 1ns/1ps

module ss_mem_model (
	input wire logic clk_in,
	input wire logic chip_select_b_in,
	input wire logic output_enable_b_in,
	input wire logic [ss_read_pkg::ADDR_W-1:0] word_addr_in,
	output logic [ss_read_pkg::DATA_W-1:0] data_out
);
	logic [ss_read_pkg::DATA_W-1:0] last_ff = 16'h0000;
	logic sel;
	assign sel = !chip_select_b_in && !output_enable_b_in;
	// a released bus keeps changing so a late sample cannot pass by luck
	always_comb begin
		data_out = sel ? (word_addr_in[15:0] ^ 16'h3c5a) : ~last_ff;
	end
	always_ff @(posedge clk_in) begin
		last_ff <= data_out;
	end
endmodule : ss_mem_model

// [bench/async_select_strobe_read_bench.sv]
// self-checking bench for the select-strobe read sequencer
`timescale 1ns/1ps

module async_select_strobe_read_bench;
	logic clk_in = 1'h0;
	logic rst_b_in = 1'h0;
	ss_read_pkg::async_bank_config_s cfg [4];
	logic req_valid_in = 1'h0;
	ss_read_pkg::read_req_s req_in = '0;
	logic req_ready_out, rd_valid_out, busy_out, we_b, dir, cs_b, oe_b;
	logic [ss_read_pkg::WORD_W-1:0] rd_data_out;
	logic [ss_read_pkg::ADDR_W-1:0] word_addr;
	logic [ss_read_pkg::ADDR_W-1:0] exp_addr = '0;
	logic [ss_read_pkg::BANK_W-1:0] bank_addr;
	logic [ss_read_pkg::BANK_W-1:0] exp_bank = '0;
	logic [ss_read_pkg::DATA_W-1:0] data_bus;
	logic active = 1'h0;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int lows = 0;

	always #12.5 clk_in = ~clk_in;

	ss_read_seq dut_u (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg), .req_valid_in(req_valid_in), .req_in(req_in),
		.req_ready_out(req_ready_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.busy_out(busy_out), .write_enable_pin_b_out(we_b), .read_write_dir_pin_out(dir),
		.chip_select_strobe_pin_b_out(cs_b), .output_enable_pin_b_out(oe_b),
		.word_addr_pins_out(word_addr), .bank_addr_pins_out(bank_addr), .data_bus_pins_in(data_bus)
	);

	ss_mem_model mem_u (
		.clk_in(clk_in), .chip_select_b_in(cs_b), .output_enable_b_in(oe_b),
		.word_addr_in(word_addr), .data_out(data_bus)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pat(input logic [21:0] a);
		return a[15:0] ^ 16'h3c5a;
	endfunction : pat

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// entered at a falling edge; gap 0 issues at once so the read follows the last completion
	task automatic rd(input logic [1:0] c, input logic [21:0] a, input int t, input int gap, input bit mut);
		int s, st, h, nb, n;
		logic [31:0] exp;
		ss_read_pkg::async_bank_config_s k;
		k = cfg[c];
		s = (k.read_setup_count == 0) ? 1 : int'(k.read_setup_count);
		st = (k.read_strobe_count == 0) ? 1 : int'(k.read_strobe_count);
		h = (k.read_hold_count == 0) ? 1 : int'(k.read_hold_count);
		nb = k.narrow_bus ? 2 : 1;
		repeat (gap) @(negedge clk_in);
		if (gap > 0) chk(32'({word_addr, bank_addr}), 32'h0000_0000, "idle addr");
		exp_addr = a;
		exp_bank = ~c;
		req_in = '{c, a, ~c};
		req_valid_in = 1'h1;
		// ready is judged at the falling edge, where it has settled; the next rising edge takes
		while (req_ready_out !== 1'h1) @(negedge clk_in);
		lows = 0;
		active = 1'h1;
		@(negedge clk_in);
		req_valid_in = 1'h0;
		chk(32'({req_ready_out, busy_out}), 32'h0000_0001, "busy");
		n = 0;
		while (rd_valid_out !== 1'h1) begin
			if (n == t) chk(32'({word_addr, bank_addr}), 32'({a, ~c}), "setup addr");
			// counts changed mid-word must not reach the second beat
			if (mut && cs_b === 1'h0) cfg[c].read_strobe_count = 6'h07;
			@(negedge clk_in);
			n++;
		end
		active = 1'h0;
		cfg[c] = k;
		chk(32'(n), 32'(t + nb * (s + st + h)), "latency");
		chk(32'(lows), 32'(nb * st), "strobe cycles");
		chk(32'({req_ready_out, busy_out}), 32'h0000_0002, "ready");
		exp = k.narrow_bus ? {pat(a | 22'h00_0001), pat(a)} : {16'h0000, pat(a)};
		chk(rd_data_out, exp, "data");
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	always @(negedge clk_in) begin
		cycles++;
		if (cycles > 4000) begin
			errors++;
			$display("[FAIL] %0t timeout", $time);
			summarize();
		end
		if (rst_b_in) begin
			chk(32'(we_b & dir), 32'h0000_0001, "we dir");
			chk(32'(oe_b), 32'(cs_b), "oe with cs");
			if (cs_b === 1'h0 && active) begin
				lows++;
				chk(32'({word_addr & 22'h3f_fffe, bank_addr}), 32'({exp_addr, exp_bank}), "addr");
			end
		end
	end

	initial begin
		cfg[0] = '{1'h1, 1'h0, 2'h2, 4'h1, 6'h02, 3'h1};
		cfg[1] = '{1'h1, 1'h1, 2'h0, 4'h2, 6'h03, 3'h2};
		cfg[2] = '{1'h1, 1'h0, 2'h3, 4'h0, 6'h01, 3'h0};
		cfg[3] = '{1'h1, 1'h1, 2'h1, 4'h3, 6'h01, 3'h1};
		repeat (6) @(negedge clk_in);
		rst_b_in = 1'h1;
		rd(2'h0, 22'h00_0100, 2, 2, 1'b0);
		rd(2'h0, 22'h00_0204, 0, 0, 1'b0);
		rd(2'h1, 22'h01_0010, 1, 0, 1'b0);
		rd(2'h2, 22'h3f_fff0, 3, 3, 1'b0);
		rd(2'h3, 22'h00_0aa2, 1, 0, 1'b0);
		rd(2'h1, 22'h2a_5550, 1, 4, 1'b1);
		rd(2'h1, 22'h2a_5554, 0, 0, 1'b0);
		summarize();
	end
endmodule : async_select_strobe_read_bench
